// [verilog/aop_result_port.sv]
// Result output port: parallel, byte and serial presentation of conversion results.
`timescale 1ns/1ps
//
// Function
// - Read strobe low together with select low makes the data lines drive.
// - Active-low busy output shows a conversion in progress and serves as interrupt.
// - Conversion clock is the external clock pin or the internal oscillator.
// - Top pin is result bit 11 in parallel format, high-byte select in byte format.
// - Byte format, select low: eight byte lines carry result bits 7 to 0.
// - Byte format, select high: eight byte lines carry the upper byte.
// - Serial format provides an active-low open-drain frame strobe.
// - Serial bit clock is open-drain, derived from the active converter clock.
// - Continuous format setting keeps the serial bit clock running all the time.
// - Gated format setting stops the bit clock after a result is sent.
// - Serial data bit is valid at bit clock falling edge while strobe is low.
// - Parallel format drives result bits 10, 9 and 8 on the shared serial pins.
// - Data lines float unless select and read are both active.
// - Parallel format always drives bits 7 to 0 regardless of byte select.
// - In byte or serial formats the lower eight lines follow byte select.
// - Rising edge of the trigger input starts a conversion, asynchronous input.
// - With trigger held low, a falling select edge starts a conversion.
module aop_result_port (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic conversion_trigger,
	input wire logic ext_clk_pin,
	input wire logic high_byte_select,
	output logic busy_n,
	output logic conv_start,
	output logic conv_tick,
	input wire logic core_valid,
	input wire logic [aop_pkg::RES_W-1:0] core_result,
	output logic core_ready,
	output aop_pkg::aop_pins_t pins_out,
	output aop_pkg::aop_pins_t pins_oe_n
);
	import aop_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic edge_up(input logic now_v, input logic prev_v);
		return now_v && !prev_v;
	endfunction : edge_up

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [1:0] cs_sy_reg;
	logic [1:0] rd_sy_reg;
	logic [1:0] trig_sy_reg;
	logic [1:0] eclk_sy_reg;
	logic [1:0] hbe_sy_reg;
	logic cs_d_reg;
	logic trig_d_reg;
	logic eclk_d_reg;
	logic rd_act_d_reg;
	logic rd_act;
	logic read_end;
	logic trig_rise;
	logic cs_fall;
	logic start_req;
	aop_ctrl_t ctrl_reg;
	logic [31:0] prdata_reg;
	logic apb_setup;
	logic apb_access;
	logic addr_ok;
	logic tick_int;
	logic tick;
	logic busy_reg;
	logic conv_start_reg;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [RES_W-1:0] fifo_out_data;
	logic [FIFO_LVL_W-1:0] fifo_level;
	logic hold_valid_reg;
	logic [RES_W-1:0] hold_data_reg;
	logic advance;
	logic serial_mode;
	logic sclk_run;
	logic sclk_rise;
	aop_ser_t ser_state_reg;
	logic sclk_reg;
	logic strobe_reg;
	logic ser_bit_reg;
	logic [RES_W-1:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic frame_done_reg;
	aop_pins_t pins_next;
	aop_pins_t oe_next;
	aop_pins_t pins_reg;
	aop_pins_t oe_reg;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cs_sy_reg <= 2'h3;
			rd_sy_reg <= 2'h3;
			trig_sy_reg <= 2'h0;
			eclk_sy_reg <= 2'h0;
			hbe_sy_reg <= 2'h0;
		end else begin
			cs_sy_reg <= {cs_sy_reg[0], cs_n};
			rd_sy_reg <= {rd_sy_reg[0], rd_n};
			trig_sy_reg <= {trig_sy_reg[0], conversion_trigger};
			eclk_sy_reg <= {eclk_sy_reg[0], ext_clk_pin};
			hbe_sy_reg <= {hbe_sy_reg[0], high_byte_select};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cs_d_reg <= 1'b1;
			trig_d_reg <= 1'b0;
			eclk_d_reg <= 1'b0;
			rd_act_d_reg <= 1'b0;
		end else begin
			cs_d_reg <= cs_sy_reg[1];
			trig_d_reg <= trig_sy_reg[1];
			eclk_d_reg <= eclk_sy_reg[1];
			rd_act_d_reg <= rd_act;
		end
	end

	assign rd_act = !cs_sy_reg[1] && !rd_sy_reg[1];
	assign read_end = edge_up(rd_act_d_reg, rd_act);
	assign trig_rise = edge_up(trig_sy_reg[1], trig_d_reg);
	assign cs_fall = edge_up(cs_d_reg, cs_sy_reg[1]);

	// ------------------------------------------------------------------
	// APB register slave
	// ------------------------------------------------------------------
	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable;
	assign addr_ok = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) || (paddr == OFF_RESULT);
	assign pready = 1'b1;
	assign pslverr = apb_access && !addr_ok;
	assign prdata = prdata_reg;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= aop_ctrl_t'(CTRL_RESET);
		end else if (apb_access && pwrite && paddr == OFF_CTRL) begin
			ctrl_reg <= aop_ctrl_t'(pwdata[CTRL_W-1:0]);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdata_reg <= '0;
		end else if (apb_setup && !pwrite) begin
			prdata_reg <= '0;
			case (paddr)
				OFF_CTRL: begin
					prdata_reg[CTRL_W-1:0] <= ctrl_reg;
				end
				OFF_STATUS: begin
					prdata_reg[STAT_BUSY] <= busy_reg;
					prdata_reg[STAT_HOLD_VALID] <= hold_valid_reg;
					prdata_reg[STAT_FRAME] <= (ser_state_reg != SER_IDLE);
					prdata_reg[STAT_LVL_LSB +: FIFO_LVL_W] <= fifo_level;
				end
				OFF_RESULT: begin
					prdata_reg[RES_W-1:0] <= hold_data_reg;
				end
				default: begin
					prdata_reg <= '0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Converter clock selection
	// ------------------------------------------------------------------
	aop_tick_div #(
		.DIV(INT_CLK_DIV)
	) u_int_osc (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.tick(tick_int)
	);

	assign tick = ctrl_reg.int_clk ? tick_int : edge_up(eclk_sy_reg[1], eclk_d_reg);
	assign conv_tick = tick;

	// ------------------------------------------------------------------
	// Conversion start and busy status
	// ------------------------------------------------------------------
	assign start_req = trig_rise || (ctrl_reg.cs_start && cs_fall && !trig_sy_reg[1]);
	assign conv_start = conv_start_reg;
	assign busy_n = !busy_reg;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			conv_start_reg <= 1'b0;
		end else begin
			conv_start_reg <= start_req && !busy_reg;
		end
	end

	// A start pulse wins over a completion in the same cycle.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			busy_reg <= 1'b0;
		end else if (conv_start_reg) begin
			busy_reg <= 1'b1;
		end else if (core_valid && core_ready) begin
			busy_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Result buffer and holding register
	// ------------------------------------------------------------------
	aop_fifo #(
		.WIDTH(RES_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_valid(core_valid),
		.in_ready(core_ready),
		.in_data(core_result),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	// Parallel and spare-format results are consumed by a host read; serial formats by a sent frame.
	assign advance = serial_mode ? frame_done_reg : (read_end && hold_valid_reg);
	assign fifo_out_ready = !hold_valid_reg || advance;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hold_valid_reg <= 1'b0;
			hold_data_reg <= '0;
		end else if (fifo_out_valid && fifo_out_ready) begin
			hold_valid_reg <= 1'b1;
			hold_data_reg <= fifo_out_data;
		end else if (advance) begin
			hold_valid_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Serial bit clock
	// ------------------------------------------------------------------
	assign serial_mode = (ctrl_reg.fmt == FMT_GATED) || (ctrl_reg.fmt == FMT_CONT);
	assign sclk_run = serial_mode && ((ctrl_reg.fmt == FMT_CONT)
		|| (ser_state_reg != SER_IDLE) || !sclk_reg);
	assign sclk_rise = tick && sclk_run && !sclk_reg;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sclk_reg <= 1'b1;
		end else if (!serial_mode) begin
			sclk_reg <= 1'b1;
		end else if (tick && sclk_run) begin
			sclk_reg <= !sclk_reg;
		end
	end

	// ------------------------------------------------------------------
	// Serial frame
	// ------------------------------------------------------------------
	// Data and strobe change on bit clock rising edges only, so each bit is
	// settled for a full half period before the falling edge samples it.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ser_state_reg <= SER_IDLE;
			strobe_reg <= 1'b1;
			ser_bit_reg <= 1'b1;
			shift_reg <= '0;
			bit_cnt_reg <= '0;
			frame_done_reg <= 1'b0;
		end else if (!serial_mode) begin
			ser_state_reg <= SER_IDLE;
			strobe_reg <= 1'b1;
			ser_bit_reg <= 1'b1;
			frame_done_reg <= 1'b0;
		end else begin
			frame_done_reg <= 1'b0;
			case (ser_state_reg)
				SER_IDLE: begin
					if (hold_valid_reg && !frame_done_reg) begin
						ser_state_reg <= SER_START;
					end
				end
				SER_START: begin
					if (sclk_rise) begin
						shift_reg <= hold_data_reg;
						ser_bit_reg <= hold_data_reg[RES_W-1];
						strobe_reg <= 1'b0;
						bit_cnt_reg <= '0;
						ser_state_reg <= SER_SHIFT;
					end
				end
				SER_SHIFT: begin
					if (sclk_rise) begin
						if (bit_cnt_reg == SER_LAST_BIT) begin
							strobe_reg <= 1'b1;
							ser_bit_reg <= 1'b1;
							ser_state_reg <= SER_DONE;
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							shift_reg <= {shift_reg[RES_W-2:0], 1'b0};
							ser_bit_reg <= shift_reg[RES_W-2];
						end
					end
				end
				SER_DONE: begin
					frame_done_reg <= 1'b1;
					ser_state_reg <= SER_IDLE;
				end
				default: begin
					ser_state_reg <= SER_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Pin multiplexing
	// ------------------------------------------------------------------
	always_comb begin
		pins_next = '0;
		oe_next = '1;
		case (ctrl_reg.fmt)
			FMT_GATED, FMT_CONT: begin
				if (hbe_sy_reg[1]) begin
					pins_next.upper = 4'h0;
					pins_next.lower = hold_data_reg[11:8];
				end else begin
					pins_next.upper = hold_data_reg[7:4];
					pins_next.lower = hold_data_reg[3:0];
				end
				if (rd_act) begin
					oe_next.upper = 4'h0;
					oe_next.lower = 4'h0;
				end
				oe_next.msb = 1'b1;
				oe_next.bit10 = strobe_reg;
				oe_next.bit9 = sclk_reg;
				oe_next.bit8 = ser_bit_reg;
			end
			default: begin
				pins_next.upper = hold_data_reg[7:4];
				pins_next.lower = hold_data_reg[3:0];
				pins_next.msb = hold_data_reg[11];
				pins_next.bit10 = hold_data_reg[10];
				pins_next.bit9 = hold_data_reg[9];
				pins_next.bit8 = hold_data_reg[8];
				if (rd_act) begin
					oe_next = '0;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pins_reg <= '0;
			oe_reg <= '1;
		end else begin
			pins_reg <= pins_next;
			oe_reg <= oe_next;
		end
	end

	assign pins_out = pins_reg;
	assign pins_oe_n = oe_reg;

endmodule : aop_result_port

// [include/aop_pkg.sv]
// Shared constants, enumerations and pin bundles of the result output port.
package aop_pkg;

	// ------------------------------------------------------------------
	// Result and buffer sizes
	// ------------------------------------------------------------------
	localparam int RES_W = 12;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_LVL_W = 4;
	localparam logic [3:0] SER_LAST_BIT = 4'hb;

	// ------------------------------------------------------------------
	// Register map (byte addresses) and field positions
	// ------------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_RESULT = 8'h08;
	localparam int CTRL_FMT_LSB = 0;
	localparam int CTRL_INT_CLK = 2;
	localparam int CTRL_CS_START = 3;
	localparam int CTRL_W = 4;
	localparam logic [3:0] CTRL_RESET = 4'h5;
	localparam int STAT_BUSY = 0;
	localparam int STAT_HOLD_VALID = 1;
	localparam int STAT_FRAME = 2;
	localparam int STAT_LVL_LSB = 4;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int INT_CLK_PERIOD_NS = 400;
	localparam int INT_CLK_DIV = (INT_CLK_PERIOD_NS * 1000) / CLK_PERIOD_PS;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		FMT_GATED = 2'h0,
		FMT_PARALLEL = 2'h1,
		FMT_CONT = 2'h2,
		FMT_SPARE = 2'h3
	} aop_fmt_t;

	typedef enum logic [1:0] {
		SER_IDLE = 2'h0,
		SER_START = 2'h1,
		SER_SHIFT = 2'h3,
		SER_DONE = 2'h2
	} aop_ser_t;

	typedef struct packed {
		logic cs_start;
		logic int_clk;
		aop_fmt_t fmt;
	} aop_ctrl_t;

	typedef struct packed {
		logic [3:0] upper;
		logic [3:0] lower;
		logic msb;
		logic bit10;
		logic bit9;
		logic bit8;
	} aop_pins_t;

endpackage : aop_pkg

// [verilog/aop_fifo.sv]
// Parameterised result FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module aop_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg < (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_ptr_reg];
	assign level = count_reg;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule : aop_fifo

// [verilog/aop_tick_div.sv]
// Divider that turns the system clock into the internal converter clock enable.
`timescale 1ns/1ps
module aop_tick_div #(
	parameter int DIV = 80
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	output logic tick
);
	logic [7:0] cnt_reg;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			tick <= 1'b0;
		end else if (cnt_reg == 8'(DIV - 1)) begin
			cnt_reg <= '0;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			tick <= 1'b0;
		end
	end
endmodule : aop_tick_div

// [verification/aop_result_port_chk.sv]
// Assertions on the pins and handshakes of the result output port.
`timescale 1ns/1ps
module aop_result_port_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic conversion_trigger,
	input wire logic busy_n,
	input wire logic conv_start,
	input wire logic conv_tick,
	input wire logic core_valid,
	input wire logic core_ready,
	input wire aop_pkg::aop_pins_t pins_oe_n
);
	import aop_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	a_read_drives: assert property (
		(!cs_n && !rd_n) [*5] |-> {pins_oe_n.upper, pins_oe_n.lower} == 8'h00)
		else $error("Byte lines not driven during a read.");
	a_idle_float: assert property (
		(cs_n || rd_n) [*5] |-> {pins_oe_n.upper, pins_oe_n.lower} == 8'hff)
		else $error("Byte lines driven without a read.");
	a_busy_on: assert property (conv_start |=> !busy_n)
		else $error("Busy not shown after a start.");
	a_busy_hold: assert property (
		!busy_n && !(core_valid && core_ready) |=> !busy_n)
		else $error("Busy dropped before the result was taken.");
	a_busy_done: assert property (!busy_n && core_valid && core_ready |=> busy_n)
		else $error("Busy kept after the result was taken.");
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("Start pulse longer than one cycle.");
	a_trig_start: assert property (
		busy_n && $rose(conversion_trigger) |-> ##[1:6] conv_start)
		else $error("Trigger edge did not start a conversion.");
	a_tick_pulse: assert property (conv_tick |=> !conv_tick)
		else $error("Converter tick longer than one cycle.");
endmodule : aop_result_port_chk

// [verification/aop_core_model.sv]
// Behavioural conversion engine that answers start pulses with results.
`timescale 1ns/1ps
module aop_core_model (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic conv_start,
	input wire logic conv_tick,
	input wire logic core_ready,
	input wire logic [11:0] next_result,
	input wire logic [2:0] conv_ticks,
	output logic core_valid,
	output logic [11:0] core_result
);
	logic run_reg;
	logic [2:0] cnt_reg;
	logic [11:0] word_reg;
	// The result is ready after conv_ticks plus one converter ticks.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			run_reg <= 1'b0;
			cnt_reg <= 3'h0;
			word_reg <= 12'h000;
			core_valid <= 1'b0;
		end else if (conv_start) begin
			run_reg <= 1'b1;
			cnt_reg <= conv_ticks;
			word_reg <= next_result;
		end else if (run_reg && conv_tick) begin
			run_reg <= (cnt_reg != 3'h0);
			core_valid <= (cnt_reg == 3'h0);
			cnt_reg <= cnt_reg - 3'h1;
		end else if (core_valid && core_ready)
			core_valid <= 1'b0;
	end
	// Once the word is taken the lines stop showing it.
	assign core_result = core_valid ? word_reg : ~word_reg;
endmodule : aop_core_model

// [verification/aop_result_port_tb.sv]
// Self-checking bench for the result output port with a reference queue.
`timescale 1ns/1ps
module aop_result_port_tb;
	import aop_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic conversion_trigger = 1'b0;
	logic ext_clk_pin = 1'b0;
	logic high_byte_select = 1'b0;
	logic [11:0] next_result = 12'h000;
	logic [2:0] conv_ticks = 3'h0;
	logic [31:0] prdata;
	logic pready, pslverr, busy_n, conv_start, conv_tick, core_valid, core_ready;
	logic [RES_W-1:0] core_result;
	aop_pins_t pins_out, pins_oe_n;
	logic [1:0] ext_cnt = 2'h0;
	logic sclk_w, strb_w, sdat_w, err;
	logic sclk_prev = 1'b1;
	logic ser_on = 1'b0;
	logic [11:0] ser_word = 12'h000;
	logic [11:0] exp_q[$];
	logic [31:0] rd;
	int failures = 0;
	int n_checks = 0;
	int ser_cnt = 0;
	int sclk_edges = 0;
	aop_result_port dut_u (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .cs_n, .rd_n, .conversion_trigger, .ext_clk_pin,
		.high_byte_select, .busy_n, .conv_start, .conv_tick, .core_valid, .core_result,
		.core_ready, .pins_out, .pins_oe_n);
	aop_core_model core_u (.clk_sys, .rst_b, .conv_start, .conv_tick, .core_ready,
		.next_result, .conv_ticks, .core_valid, .core_result);
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		ext_cnt <= ext_cnt + 2'h1;
		if (ext_cnt == 2'h3)
			ext_clk_pin <= ~ext_clk_pin;
	end
	always @(posedge clk_sys)
		if (conv_start === 1'b1) begin
			exp_q.push_back(next_result);
			next_result <= 12'($urandom);
		end
	// Open-drain serial pins read high through their pull-ups when released.
	assign sclk_w = pins_oe_n.bit9 | pins_out.bit9;
	assign strb_w = pins_oe_n.bit10 | pins_out.bit10;
	assign sdat_w = pins_oe_n.bit8 | pins_out.bit8;
	always @(posedge clk_sys) begin
		if (sclk_w !== sclk_prev)
			sclk_edges++;
		if (ser_on && sclk_prev && !sclk_w && !strb_w) begin
			ser_word = {ser_word[10:0], sdat_w};
			ser_cnt++;
			if (ser_cnt == 12) begin
				check_eq(ser_word, exp_q.pop_front());
				ser_cnt = 0;
			end
		end
		sclk_prev = sclk_w;
	end
	task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check_eq
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb_xfer
	task automatic wait_busy(input logic v);
		int k;
		k = 0;
		while (busy_n !== v && k < 2000) begin
			@(posedge clk_sys);
			k++;
		end
		check_eq(busy_n, v);
	endtask : wait_busy
	task automatic wait_drain();
		int k;
		k = 0;
		while (exp_q.size() != 0 && k < 2000) begin
			@(posedge clk_sys);
			k++;
		end
		check_eq(exp_q.size(), 0);
	endtask : wait_drain
	task automatic convert(input bit done);
		conv_ticks <= 3'($urandom_range(3, 0));
		conversion_trigger <= 1'b1;
		wait_busy(1'b0);
		conversion_trigger <= 1'b0;
		if (done)
			wait_busy(1'b1);
	endtask : convert
	task automatic release_pins();
		@(posedge clk_sys);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		check_eq(pins_oe_n[11:4], 8'hff);
		@(posedge clk_sys);
	endtask : release_pins
	task automatic read_par(input logic [11:0] d);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		check_eq(pins_oe_n, 12'h000);
		check_eq(pins_out, {d[7:0], d[11:8]});
		release_pins();
	endtask : read_par
	task automatic read_byte(input logic hbs, input logic [11:0] d);
		high_byte_select <= hbs;
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		check_eq(pins_out[11:4], hbs ? {4'h0, d[11:8]} : d[7:0]);
		check_eq(pins_oe_n.msb, 1'b1);
		release_pins();
	endtask : read_byte
	initial begin
		void'($urandom(67181));
		next_result = 12'($urandom);
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		apb_xfer(1'b0, OFF_CTRL, 32'h0, rd, err);
		check_eq(rd, 32'h5);
		check_eq(err, 1'b0);
		apb_xfer(1'b0, 8'h0c, 32'h0, rd, err);
		check_eq(err, 1'b1);
		apb_xfer(1'b1, OFF_STATUS, 32'hffff_ffff, rd, err);
		apb_xfer(1'b0, OFF_STATUS, 32'h0, rd, err);
		check_eq(rd, 32'h0);
		convert(1'b1);
		apb_xfer(1'b0, OFF_RESULT, 32'h0, rd, err);
		check_eq(rd, {20'h0, exp_q[0]});
		check_eq(err, 1'b0);
		read_par(exp_q.pop_front());
		apb_xfer(1'b1, OFF_CTRL, 32'h1, rd, err);
		for (int i = 0; i < 10; i++)
			convert(i < 9);
		apb_xfer(1'b0, OFF_STATUS, 32'h0, rd, err);
		check_eq(rd, 32'h83);
		for (int i = 0; i < 10; i++) begin
			high_byte_select <= i[0];
			read_par(exp_q.pop_front());
		end
		apb_xfer(1'b1, OFF_CTRL, 32'h9, rd, err);
		cs_n <= 1'b0;
		wait_busy(1'b0);
		cs_n <= 1'b1;
		wait_busy(1'b1);
		apb_xfer(1'b1, OFF_CTRL, 32'h1, rd, err);
		read_par(exp_q.pop_front());
		ser_on = 1'b1;
		apb_xfer(1'b1, OFF_CTRL, 32'h0, rd, err);
		convert(1'b1);
		read_byte(1'b0, exp_q[0]);
		read_byte(1'b1, exp_q[0]);
		wait_drain();
		repeat (8) @(posedge clk_sys);
		sclk_edges = 0;
		repeat (40) @(posedge clk_sys);
		check_eq(sclk_edges, 0);
		check_eq(strb_w, 1'b1);
		apb_xfer(1'b1, OFF_CTRL, 32'h2, rd, err);
		convert(1'b1);
		wait_drain();
		sclk_edges = 0;
		repeat (40) @(posedge clk_sys);
		check_eq(sclk_edges != 0, 1'b1);
		tally_and_finish();
	end
	initial begin
		repeat (40000) @(posedge clk_sys);
		failures++;
		tally_and_finish();
	end
endmodule : aop_result_port_tb
bind aop_result_port aop_result_port_chk chk_u (.clk_sys, .rst_b, .cs_n, .rd_n,
	.conversion_trigger, .busy_n, .conv_start, .conv_tick, .core_valid, .core_ready, .pins_oe_n);
